//--- debug_monitor_freeze_ctrl.sv
// Core bus monitor outputs, pipe status, emulator interrupt and freeze gating
//
// Functional notes
// - Drive transaction type code in first phase of each core bus cycle.
// - Drive code 000 on all other cycles, including second byte cycle.
// - Assert external, base or io zone select for those off-chip accesses.
// - On-chip accesses keep zone selects low, show address, enables, read flag.
// - Low lane enable for even byte, high lane enable for odd byte.
// - Read flag high on reads, low on writes.
// - Pulse pipe flow output on each instruction completion.
// - Instruction size flag 0 word, 1 double word, with completion.
// - Non-sequential fetch after flush comes no earlier than next cycle.
// - Debug configuration is 8-bit read/write, zero after reset.
// - Outside dev environment debug-enable stays 0, writes ignored.
// - Debug-enable allows emulator interrupt and other debug bits.
// - Emulator interrupt is falling-edge NMI when enabled, else ignored.
// - Freeze with debug-enable stops the watchdog counter.
// - Frozen watchdog keeps its count and resumes from it.
// - While frozen, reads cause no side effects.
// - NMI status register reads are unaffected by freeze.
// - Freeze bit has no effect while debug-enable is 0.
// - Freeze enable register is 8-bit read/write, zero after reset.
// - Freeze enable bit 0 freezes the multi-function timer.
// - Freeze enable bit 1 freezes the two-wire bus interface.
module debug_monitor_freeze_ctrl
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Environment
  input  wire logic        devEnvironment,
  // Avalon-MM slave
  input  wire logic [1:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Core bus activity
  input  wire logic        coreCycleStart,
  input  wire logic [2:0]  coreCycleType,
  input  wire logic [1:0]  coreZone,
  input  wire logic [12:0] coreAddress,
  input  wire logic        coreByteAccess,
  input  wire logic        coreRead,
  // Core pipe activity
  input  wire logic        instrComplete,
  input  wire logic        instrDouble,
  // Core read strobes
  input  wire logic        coreReadStrobe,
  input  wire logic        nmiStatusRead,
  // Emulator interrupt and watchdog
  input  wire logic        emulatorInterrupt_n,
  input  wire logic        watchdogTick,
  input  wire logic        watchdogRefresh,
  // Monitor outputs
  output logic      [2:0]  busTransactionType,
  output logic             externalZoneSelect,
  output logic             baseZoneSelect,
  output logic             ioExpansionSelect,
  output logic      [12:0] monitorAddress,
  output logic             lowByteLaneEnable,
  output logic             highByteLaneEnable,
  output logic             coreReadFlag,
  output logic             pipeFlowPulse,
  output logic             instructionSizeFlag,
  // Freeze and interrupt outputs
  output logic             emulatorNmi,
  output logic             readSideEffectEnable,
  output logic             nmiStatusReadEnable,
  output logic             timerFreeze,
  output logic             twoWireFreeze,
  output logic      [15:0] watchdogCount
);

  freeze_gate_if gate ();

  ////////////////////////////////////////////////////////////////////////////
  // Register block

  debug_regs regs_i
  (
    .ref_clk        (ref_clk),
    .reset_n        (reset_n),
    .devEnvironment (devEnvironment),
    .address        (address),
    .read           (read),
    .write          (write),
    .writedata      (writedata),
    .byteenable     (byteenable),
    .statusByte     ({4'h0, gate.twoWireFreeze, gate.timerFreeze, gate.freezeActive,
                      gate.debugOn}),
    .readdata       (readdata),
    .waitrequest    (waitrequest),
    .gate           (gate)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus monitor

  logic [2:0]  bst_q, bst_d;
  logic        external_zone_select_q, external_zone_select_d, base_zone_select_q, base_zone_select_d, io_expansion_select_q, io_expansion_select_d;
  logic [12:0] addr_q, addr_d;
  logic        be0_q, be0_d, be1_q, be1_d, rd_q, rd_d;
  logic        pfs_q, pfs_d, pli_q, pli_d;

  // Monitor next values
  always_comb
  begin
    bst_d   = debug_monitor_pkg::BT_IDLE;
    external_zone_select_d  = 1'b0;
    base_zone_select_d  = 1'b0;
    io_expansion_select_d = 1'b0;
    addr_d  = addr_q;
    be0_d   = be0_q;
    be1_d   = be1_q;
    rd_d    = rd_q;
    if (coreCycleStart)
    begin
      bst_d  = coreCycleType;
      addr_d = coreAddress;
      be0_d  = !coreByteAccess || !coreAddress[0];
      be1_d  = !coreByteAccess || coreAddress[0];
      rd_d   = coreRead;
      unique case (debug_monitor_pkg::zone_t'(coreZone))
        debug_monitor_pkg::ZONE_EXTERNAL: external_zone_select_d  = 1'b1;
        debug_monitor_pkg::ZONE_BASE:     base_zone_select_d  = 1'b1;
        debug_monitor_pkg::ZONE_IO:       io_expansion_select_d = 1'b1;
        debug_monitor_pkg::ZONE_ONCHIP:   external_zone_select_d  = 1'b0;
      endcase
    end
    pfs_d = instrComplete;
    pli_d = instrComplete & instrDouble;
  end

  // Monitor registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bst_q   <= debug_monitor_pkg::BT_IDLE;
      external_zone_select_q  <= 1'b0;
      base_zone_select_q  <= 1'b0;
      io_expansion_select_q <= 1'b0;
      addr_q  <= 13'h0000;
      be0_q   <= 1'b0;
      be1_q   <= 1'b0;
      rd_q    <= 1'b0;
      pfs_q   <= 1'b0;
      pli_q   <= 1'b0;
    end
    else
    begin
      bst_q   <= bst_d;
      external_zone_select_q  <= external_zone_select_d;
      base_zone_select_q  <= base_zone_select_d;
      io_expansion_select_q <= io_expansion_select_d;
      addr_q  <= addr_d;
      be0_q   <= be0_d;
      be1_q   <= be1_d;
      rd_q    <= rd_d;
      pfs_q   <= pfs_d;
      pli_q   <= pli_d;
    end
  end

  // Monitor outputs from flops
  assign busTransactionType  = bst_q;
  assign externalZoneSelect  = external_zone_select_q;
  assign baseZoneSelect      = base_zone_select_q;
  assign ioExpansionSelect   = io_expansion_select_q;
  assign monitorAddress      = addr_q;
  assign lowByteLaneEnable   = be0_q;
  assign highByteLaneEnable  = be1_q;
  assign coreReadFlag        = rd_q;
  assign pipeFlowPulse       = pfs_q;
  assign instructionSizeFlag = pli_q;

  ////////////////////////////////////////////////////////////////////////////
  // Emulator interrupt and watchdog

  logic        iseLast_q, iseLast_d, nmi_q, nmi_d;
  logic [15:0] wdog_q, wdog_d;

  // Interrupt edge and watchdog next values
  always_comb
  begin
    iseLast_d = emulatorInterrupt_n;
    nmi_d = gate.debugOn & iseLast_q & !emulatorInterrupt_n;
    wdog_d = wdog_q;
    if (watchdogRefresh)
      wdog_d = debug_monitor_pkg::WDOG_RESET;
    else if (watchdogTick && !gate.freezeActive)
      wdog_d = wdog_q + 16'h0001;
  end

  // Interrupt and watchdog registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      iseLast_q <= 1'b1;
      nmi_q     <= 1'b0;
      wdog_q    <= debug_monitor_pkg::WDOG_RESET;
    end
    else
    begin
      iseLast_q <= iseLast_d;
      nmi_q     <= nmi_d;
      wdog_q    <= wdog_d;
    end
  end

  assign emulatorNmi   = nmi_q;
  assign watchdogCount = wdog_q;

  assign readSideEffectEnable = coreReadStrobe & !gate.freezeActive;
  assign nmiStatusReadEnable  = nmiStatusRead;
  assign timerFreeze   = gate.timerFreeze;
  assign twoWireFreeze = gate.twoWireFreeze;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  idle_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !$past(coreCycleStart) |-> busTransactionType == debug_monitor_pkg::BT_IDLE)
    else $error("nonzero code outside first phase");
  type_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    coreCycleStart |=> busTransactionType == $past(coreCycleType))
    else $error("transaction code mismatch");
  zone_sel_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    coreCycleStart |=>
      (externalZoneSelect == ($past(coreZone) == debug_monitor_pkg::ZONE_EXTERNAL))
      && (baseZoneSelect == ($past(coreZone) == debug_monitor_pkg::ZONE_BASE))
      && (ioExpansionSelect == ($past(coreZone) == debug_monitor_pkg::ZONE_IO)))
    else $error("zone select mismatch");
  onchip_sel_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    coreCycleStart && coreZone == debug_monitor_pkg::ZONE_ONCHIP |=>
      !externalZoneSelect && !baseZoneSelect && !ioExpansionSelect)
    else $error("zone select on on-chip access");
  addr_shown_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    coreCycleStart |=> monitorAddress == $past(coreAddress))
    else $error("monitor address mismatch");
  odd_lane_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    coreCycleStart && coreByteAccess && coreAddress[0] |=>
      highByteLaneEnable && !lowByteLaneEnable)
    else $error("odd byte lane wrong");
  even_lane_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    coreCycleStart && coreByteAccess && !coreAddress[0] |=>
      lowByteLaneEnable && !highByteLaneEnable)
    else $error("even byte lane wrong");
  word_lanes_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    coreCycleStart && !coreByteAccess |=> lowByteLaneEnable && highByteLaneEnable)
    else $error("word lanes wrong");
  read_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    coreCycleStart |=> coreReadFlag == $past(coreRead))
    else $error("read flag mismatch");

  pipe_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pipeFlowPulse == $past(instrComplete))
    else $error("pipe flow pulse mismatch");
  size_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    instructionSizeFlag == (pipeFlowPulse && $past(instrDouble)))
    else $error("instruction size flag mismatch");
  fetch_order_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    instrComplete ##1 (coreCycleStart && coreCycleType == debug_monitor_pkg::BT_NSEQ_FET)
      |=> busTransactionType == debug_monitor_pkg::BT_NSEQ_FET && $past(pipeFlowPulse))
    else $error("fetch shown before pipe pulse");

  wdog_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    gate.freezeActive && !watchdogRefresh |=> $stable(watchdogCount))
    else $error("watchdog moved while frozen");
  wdog_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    watchdogTick && !watchdogRefresh && !gate.freezeActive |=>
      watchdogCount == $past(watchdogCount) + 16'h0001)
    else $error("watchdog did not count");

  nmi_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !$past(gate.debugOn) |-> !emulatorNmi)
    else $error("emulator nmi while disabled");
  nmi_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    gate.debugOn && $fell(emulatorInterrupt_n) |=> emulatorNmi)
    else $error("emulator nmi missed");
  nmi_single_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    emulatorNmi |=> !emulatorNmi)
    else $error("emulator nmi longer than one cycle");

  freeze_on_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !gate.debugOn |-> !timerFreeze && !twoWireFreeze
      && readSideEffectEnable == coreReadStrobe)
    else $error("freeze effective without debug enable");
  read_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    gate.freezeActive |-> !readSideEffectEnable)
    else $error("read side effect while frozen");
  nmi_exempt_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    nmiStatusReadEnable == nmiStatusRead)
    else $error("nmi status read blocked");
  timer_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    timerFreeze |-> gate.freezeActive)
    else $error("timer frozen without freeze");
  wire_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    twoWireFreeze |-> gate.freezeActive)
    else $error("two-wire frozen without freeze");

endmodule : debug_monitor_freeze_ctrl

//--- debug_monitor_pkg.sv
// Shared constants and types for the debug monitor and freeze control block
package debug_monitor_pkg;

  // Register map (word addresses on the Avalon-MM slave)
  localparam logic [1:0] ADDR_DEBUG_CFG    = 2'h0;
  localparam logic [1:0] ADDR_FREEZE_EN    = 2'h1;
  localparam logic [1:0] ADDR_STATUS       = 2'h2;

  // Field positions
  localparam int CFG_ON_BIT       = 0;
  localparam int CFG_FREEZE_BIT   = 1;
  localparam int FEN_TIMER_BIT    = 0;
  localparam int FEN_TWO_WIRE_BIT = 1;

  // Reset values and writable masks
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] FEN_RESET     = 8'h00;
  localparam logic [7:0] WRITABLE_MASK = 8'h03;

  // Watchdog width and reset value
  localparam int          WDOG_W     = 16;
  localparam logic [15:0] WDOG_RESET = 16'h0000;

  // Bus transaction type codes
  typedef enum logic [2:0] {
    BT_IDLE     = 3'b000,
    BT_WAIT_INT = 3'b001,
    BT_INT_ACK  = 3'b010,
    BT_NONCORE  = 3'b011,
    BT_SEQ_FET  = 3'b100,
    BT_NSEQ_FET = 3'b101,
    BT_CORE_DAT = 3'b110,
    BT_EXC_DAT  = 3'b111
  } bus_type_t;

  // Zone codes of a core access
  typedef enum logic [1:0] {
    ZONE_ONCHIP   = 2'b00,
    ZONE_EXTERNAL = 2'b01,
    ZONE_BASE     = 2'b10,
    ZONE_IO       = 2'b11
  } zone_t;

endpackage : debug_monitor_pkg

//--- debug_regs.sv
// Debug configuration and freeze enable registers with Avalon-MM slave
module debug_regs
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Environment
  input  wire logic        devEnvironment,
  // Avalon-MM slave
  input  wire logic [1:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  input  wire logic [7:0]  statusByte,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Freeze controls
  freeze_gate_if.regs      gate
);

  logic [7:0]  cfg_q, cfg_d;
  logic [7:0]  fen_q, fen_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;

  // One wait cycle: request answered on the second edge
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata    = rdata_q;

  // Next-state of registers
  always_comb
  begin
    cfg_d   = cfg_q;
    fen_d   = fen_q;
    rdata_d = rdata_q;
    ack_d   = 1'b0;
    // Write lands only on the edge where waitrequest is seen low
    if (write && ack_q && byteenable[0])
    begin
      unique case (address)
        debug_monitor_pkg::ADDR_DEBUG_CFG:
        begin
          cfg_d = writedata[7:0] & debug_monitor_pkg::WRITABLE_MASK;
          if (!devEnvironment)
            cfg_d[debug_monitor_pkg::CFG_ON_BIT] = 1'b0;
        end
        debug_monitor_pkg::ADDR_FREEZE_EN:
          fen_d = writedata[7:0] & debug_monitor_pkg::WRITABLE_MASK;
        default:
          fen_d = fen_q;
      endcase
    end
    // First edge of a request: read data latched, stands at the completing edge
    if ((read | write) && !ack_q)
    begin
      ack_d = 1'b1;
      if (read)
      begin
        unique case (address)
          debug_monitor_pkg::ADDR_DEBUG_CFG: rdata_d = {24'h000000, cfg_q};
          debug_monitor_pkg::ADDR_FREEZE_EN: rdata_d = {24'h000000, fen_q};
          debug_monitor_pkg::ADDR_STATUS:    rdata_d = {24'h000000, statusByte};
          default:                           rdata_d = 32'h00000000;
        endcase
      end
    end
    if (!devEnvironment)
      cfg_d[debug_monitor_pkg::CFG_ON_BIT] = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q   <= debug_monitor_pkg::CFG_RESET;
      fen_q   <= debug_monitor_pkg::FEN_RESET;
      rdata_q <= 32'h00000000;
      ack_q   <= 1'b0;
    end
    else
    begin
      cfg_q   <= cfg_d;
      fen_q   <= fen_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  assign gate.debugOn       = cfg_q[debug_monitor_pkg::CFG_ON_BIT];
  assign gate.freezeActive  = cfg_q[debug_monitor_pkg::CFG_ON_BIT]
                            & cfg_q[debug_monitor_pkg::CFG_FREEZE_BIT];
  assign gate.timerFreeze   = gate.freezeActive & fen_q[debug_monitor_pkg::FEN_TIMER_BIT];
  assign gate.twoWireFreeze = gate.freezeActive & fen_q[debug_monitor_pkg::FEN_TWO_WIRE_BIT];

  // Reserved bits stay zero
  // reserved read zero
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfg_q[7:2] == 6'h00) && (fen_q[7:2] == 6'h00))
    else $error("reserved bits set");
  on_outside_dev_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !$past(devEnvironment) |-> !cfg_q[debug_monitor_pkg::CFG_ON_BIT])
    else $error("on bit set outside dev");

endmodule : debug_regs

//--- dev_tool_model.sv
// Development tool model: register master and emulator interrupt driver
module dev_tool_model
(
  // Clock
  input  wire logic        ref_clk,
  // Avalon-MM master
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [1:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable,
  // Emulator interrupt
  output logic             emulatorInterrupt_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus and released interrupt line at time zero
  initial
  begin
    address = 2'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h1;
    emulatorInterrupt_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // tool-only register access
  // Request held until waitrequest is sampled low at a rising edge
  task automatic avWrite(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= {24'h000000, d};
    write <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : avWrite

  // tool-only register access
  // Read data is taken at the completing edge
  task automatic avRead(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    address <= a;
    read <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    d = readdata[7:0];
    read <= 1'b0;
  endtask : avRead

  // Drive the active-low interrupt line
  task automatic setIse(input logic v);
    @(posedge ref_clk);
    emulatorInterrupt_n <= v;
  endtask : setIse
endmodule : dev_tool_model

//--- freeze_gate_if.sv
// Interface carrying freeze controls from the register block to the monitor
interface freeze_gate_if;
  logic debugOn;
  logic freezeActive;
  logic timerFreeze;
  logic twoWireFreeze;

  modport regs (output debugOn, output freezeActive, output timerFreeze, output twoWireFreeze);
  modport core (input debugOn, input freezeActive, input timerFreeze, input twoWireFreeze);
endinterface : freeze_gate_if

//--- testbench.sv
// Self-checking testbench for the debug monitor and freeze control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0, reset_n = 1'b0, devEnvironment = 1'b1;
  logic [1:0]  address;
  logic        read, write, waitrequest, emulatorInterrupt_n;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic        coreCycleStart = 1'b0, coreByteAccess = 1'b0, coreRead = 1'b0;
  logic [2:0]  coreCycleType = 3'h1;
  logic [1:0]  coreZone = 2'h0;
  logic [12:0] coreAddress = 13'h0000;
  logic        instrComplete = 1'b0, instrDouble = 1'b0, coreReadStrobe = 1'b0;
  logic        nmiStatusRead = 1'b0, watchdogTick = 1'b0, watchdogRefresh = 1'b0;
  logic [2:0]  busTransactionType;
  logic        externalZoneSelect, baseZoneSelect, ioExpansionSelect;
  logic [12:0] monitorAddress;
  logic        lowByteLaneEnable, highByteLaneEnable, coreReadFlag, pipeFlowPulse;
  logic        instructionSizeFlag, emulatorNmi, readSideEffectEnable;
  logic        nmiStatusReadEnable, timerFreeze, twoWireFreeze;
  logic [15:0] watchdogCount;
  int          failures = 0, n_tests = 0, cycles = 0;

  debug_monitor_freeze_ctrl u_debug_monitor_freeze_ctrl
  (
    .ref_clk, .reset_n, .devEnvironment, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .coreCycleStart, .coreCycleType,
    .coreZone, .coreAddress, .coreByteAccess, .coreRead, .instrComplete,
    .instrDouble, .coreReadStrobe, .nmiStatusRead, .emulatorInterrupt_n,
    .watchdogTick, .watchdogRefresh, .busTransactionType, .externalZoneSelect,
    .baseZoneSelect, .ioExpansionSelect, .monitorAddress, .lowByteLaneEnable,
    .highByteLaneEnable, .coreReadFlag, .pipeFlowPulse, .instructionSizeFlag,
    .emulatorNmi, .readSideEffectEnable, .nmiStatusReadEnable, .timerFreeze,
    .twoWireFreeze, .watchdogCount
  );

  dev_tool_model u_dev_tool_model
  (
    .ref_clk, .waitrequest, .readdata, .address, .read, .write, .writedata,
    .byteenable, .emulatorInterrupt_n
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic checkV(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : checkV

  task automatic rdChk(input logic [1:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    u_dev_tool_model.avRead(a, d);
    checkV(d & mask, exp, "register read");
  endtask : rdChk

  // Tick the watchdog for three cycles
  task automatic tick3();
    @(posedge ref_clk);
    watchdogTick <= 1'b1;
    repeat (3) @(posedge ref_clk);
    watchdogTick <= 1'b0;
    @(negedge ref_clk);
  endtask : tick3

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic regsRun();
    rdChk(2'h0, 8'hFF, 8'h00);
    rdChk(2'h1, 8'hFF, 8'h00);
    devEnvironment <= 1'b0;
    u_dev_tool_model.avWrite(2'h0, 8'hFF);
    rdChk(2'h0, 8'hFD, 8'h00);
    checkV({timerFreeze, readSideEffectEnable}, 16'h0000, "no freeze off");
    devEnvironment <= 1'b1;
    u_dev_tool_model.avWrite(2'h0, 8'hFF);
    u_dev_tool_model.avWrite(2'h1, 8'hFF);
    rdChk(2'h0, 8'hFF, 8'h03);
    rdChk(2'h1, 8'hFF, 8'h03);
    rdChk(2'h2, 8'hFF, 8'h0F);
    rdChk(2'h3, 8'hFF, 8'h00);
  endtask : regsRun

  task automatic freezeRun();
    logic [15:0] w;
    coreReadStrobe <= 1'b1;
    nmiStatusRead <= 1'b1;
    @(negedge ref_clk);
    w = watchdogCount;
    checkV({timerFreeze, twoWireFreeze}, 16'h0003, "module freeze");
    checkV(readSideEffectEnable, 16'h0000, "read effects");
    checkV(nmiStatusReadEnable, 16'h0001, "nmi status read");
    tick3();
    checkV(watchdogCount, w, "frozen count");
    // Writes land at the completing edge: look once they have settled
    u_dev_tool_model.avWrite(2'h1, 8'h01);
    @(negedge ref_clk);
    checkV({timerFreeze, twoWireFreeze}, 16'h0002, "timer only");
    u_dev_tool_model.avWrite(2'h1, 8'h02);
    @(negedge ref_clk);
    checkV({timerFreeze, twoWireFreeze}, 16'h0001, "two-wire only");
    u_dev_tool_model.avWrite(2'h0, 8'h02);
    @(negedge ref_clk);
    checkV({timerFreeze, twoWireFreeze, readSideEffectEnable}, 16'h0001, "ON low");
    tick3();
    checkV(watchdogCount, w + 16'h0003, "resumed count");
    coreReadStrobe <= 1'b0;
    nmiStatusRead <= 1'b0;
  endtask : freezeRun

  task automatic emuRun(input logic on, input logic [15:0] exp);
    logic [15:0] cnt;
    cnt = 16'h0000;
    u_dev_tool_model.avWrite(2'h0, {7'h00, on});
    u_dev_tool_model.setIse(1'b0);
    repeat (6)
    begin
      @(negedge ref_clk);
      if (emulatorNmi === 1'b1)
        cnt++;
    end
    u_dev_tool_model.setIse(1'b1);
    checkV(cnt, exp, "emulator nmi pulses");
  endtask : emuRun

  task automatic checkItem(input int j);
    logic [1:0] z;
    z = 2'(j);
    checkV(busTransactionType, 16'(j + 1), "type code");
    checkV({externalZoneSelect, baseZoneSelect, ioExpansionSelect},
           (z == 2'b00) ? 16'h0000 : 16'h0004 >> (z - 2'b01), "zone selects");
    checkV(monitorAddress, 16'h0100 + 16'(j), "monitor address");
    checkV({highByteLaneEnable, lowByteLaneEnable},
           !j[1] ? 16'h0003 : (j[0] ? 16'h0002 : 16'h0001), "byte lanes");
    checkV(coreReadFlag, 16'(j[0]), "read flag");
  endtask : checkItem

  // Back-to-back core cycles, each type code 001 to 111 once
  task automatic monitorRun();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      coreCycleStart <= (i < 7);
      coreCycleType <= 3'(i + 1);
      coreZone <= 2'(i);
      coreAddress <= 13'h0100 + 13'(i);
      coreByteAccess <= i[1];
      coreRead <= i[0];
      @(negedge ref_clk);
      if (i > 0)
        checkItem(i - 1);
    end
    @(negedge ref_clk);
    checkV(busTransactionType, 16'h0000, "idle code");
  endtask : monitorRun

  task automatic pipeRun();
    for (int d = 0; d < 2; d++)
    begin
      @(posedge ref_clk);
      instrComplete <= 1'b1;
      instrDouble <= d[0];
      @(posedge ref_clk);
      instrComplete <= 1'b0;
      // Flushing instruction: non-sequential fetch in the next cycle
      coreCycleStart <= 1'b1;
      coreCycleType <= debug_monitor_pkg::BT_NSEQ_FET;
      @(negedge ref_clk);
      checkV({pipeFlowPulse, instructionSizeFlag}, 16'h0002 + 16'(d), "pipe pulse");
      @(posedge ref_clk);
      coreCycleStart <= 1'b0;
      @(negedge ref_clk);
      checkV(pipeFlowPulse, 16'h0000, "pipe pulse end");
      checkV(busTransactionType, 16'(debug_monitor_pkg::BT_NSEQ_FET), "fetch after pulse");
    end
  endtask : pipeRun

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    regsRun();
    freezeRun();
    emuRun(1'b1, 16'h0001);
    emuRun(1'b0, 16'h0000);
    monitorRun();
    pipeRun();
    summarize();
  end
endmodule : testbench
